// >>> logic/dcf_pkg.sv
// shared constants for the dual clock fifo with programmable flags
package dcf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DCF_WIDTH       = 18;
  localparam int DCF_DEPTH_SMALL = 8192;
  localparam int DCF_DEPTH_LARGE = 16384;

  // ----------------------------------------------------------------
  // offsets after full clear reset
  // ----------------------------------------------------------------
  localparam int DCF_OFFSET_LOW  = 127;
  localparam int DCF_OFFSET_HIGH = 1023;

  // ----------------------------------------------------------------
  // values after reset, and offset index codes
  // ----------------------------------------------------------------
  localparam logic [DCF_WIDTH-1:0] DCF_OUT_RESET = 18'h00000;
  localparam logic                 DCF_IDX_EMPTY = 1'b0;
  localparam logic                 DCF_IDX_FULL  = 1'b1;

  // ----------------------------------------------------------------
  // fall-through fetch latency, write to valid output, in cycles
  // ----------------------------------------------------------------
  localparam int DCF_FT_LATENCY = 3;

endpackage : dcf_pkg

// >>> logic/dcf_mem.sv
// storage array with registered read data
`timescale 1ns/1ps
module dcf_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8192,
  parameter int AW    = 13
) (
  // clock
  input  wire logic             clock,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_array [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_array[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data <= mem_array[rd_addr];
    end
  end

endmodule // dcf_mem

// >>> logic/dcf_fifo.sv
// 18-bit fifo with standard and fall-through timing and programmable flags
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = dcf_pkg::DCF_DEPTH_SMALL
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // fifo resets
  input  wire logic                          full_clear_reset_n,
  input  wire logic                          pointer_only_reset_n,
  // write port
  input  wire logic                          write_enable_n,
  input  wire logic [dcf_pkg::DCF_WIDTH-1:0] write_data_bus,
  // read port
  input  wire logic                          read_enable_n,
  input  wire logic                          replay_request_n,
  input  wire logic                          output_enable_n,
  output logic      [dcf_pkg::DCF_WIDTH-1:0] read_data_bus,
  output logic                               read_data_oe,
  // offset programming and configuration
  input  wire logic                          fallthrough_serial_pin,
  input  wire logic                          serial_load_enable_n,
  input  wire logic                          offset_access_select_n,
  input  wire logic                          clock_ratio_select,
  // flags
  output logic                               full_space_output,
  output logic                               empty_valid_output,
  output logic                               almost_full_flag,
  output logic                               almost_empty_flag,
  output logic                               half_level_flag
);
  import dcf_pkg::*;

  localparam int          AW      = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH / 2);
  localparam logic [AW-1:0] OFF_LO = AW'(DCF_OFFSET_LOW);
  localparam logic [AW-1:0] OFF_HI = AW'(DCF_OFFSET_HIGH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [AW-1:0]        wr_ptr_r,    wr_ptr_nxt;
  logic [AW-1:0]        rd_ptr_r,    rd_ptr_nxt;
  logic [AW:0]          count_r,     count_nxt;
  logic                 pend_r,      pend_nxt;
  logic                 ov_r,        ov_nxt;
  logic [DCF_WIDTH-1:0] out_r,       out_nxt;
  logic                 ft_mode_r;
  logic                 serial_mode_r;
  logic [AW-1:0]        empty_off_r;
  logic [AW-1:0]        full_off_r;
  logic                 woff_idx_r;
  logic                 roff_idx_r;
  logic                 oe_r;
  logic                 space_r;
  logic                 ev_out_r;
  logic                 afull_r;
  logic                 aempty_r;
  logic                 half_r;
  logic [DCF_WIDTH-1:0] mem_q;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire            clr       = !full_clear_reset_n | !pointer_only_reset_n;
  wire            sel       = !offset_access_select_n & full_clear_reset_n;
  wire            wr_req    = !write_enable_n;
  wire            rd_req    = !read_enable_n;
  wire            replay    = !replay_request_n & !clr;
  wire            full      = (count_r == DEPTH_C);
  wire            mem_has   = (count_r != '0);
  wire            wr_mem    = wr_req & !sel & !full & !clr;
  wire            take_std  = !ft_mode_r & rd_req & !sel & mem_has;
  wire            take_ft   = ft_mode_r & rd_req & !sel & ov_r;
  wire            fetch_ft  = ft_mode_r & mem_has & !pend_r & (!ov_r | take_ft);
  wire            rd_mem    = !clr & !replay & (take_std | fetch_ft);
  wire            par_wr    = wr_req & sel & !serial_mode_r & !clr;
  wire            ser_wr    = !serial_load_enable_n & sel & serial_mode_r & !clr;
  wire            off_rd    = rd_req & sel & !clr;
  wire [AW-1:0]   off_val   = (roff_idx_r == DCF_IDX_FULL) ? full_off_r : empty_off_r;
  wire [AW:0]     base_cnt  = replay ? {1'b0, wr_ptr_r} : count_r;
  wire [AW:0]     free_nxt  = DEPTH_C - count_nxt;
  wire [AW-1:0]   def_off   = offset_access_select_n ? OFF_HI : OFF_LO;
  wire [2*AW-1:0] ser_chain = {fallthrough_serial_pin, full_off_r, empty_off_r[AW-1:1]};

  // ----------------------------------------------------------------
  // next values of pointers, level and output word
  // ----------------------------------------------------------------
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    pend_nxt   = rd_mem;
    ov_nxt     = ov_r;
    out_nxt    = out_r;
    if (clr) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      count_nxt  = '0;
      pend_nxt   = 1'b0;
      ov_nxt     = 1'b0;
      out_nxt    = DCF_OUT_RESET;
    end else begin
      if (wr_mem) begin
        wr_ptr_nxt = AW'(wr_ptr_r + 1'b1);
      end
      if (replay) begin
        rd_ptr_nxt = '0;
        pend_nxt   = 1'b0;
        ov_nxt     = 1'b0;
      end else if (rd_mem) begin
        rd_ptr_nxt = AW'(rd_ptr_r + 1'b1);
      end
      count_nxt = (AW+1)'(base_cnt + {{AW{1'b0}}, wr_mem} - {{AW{1'b0}}, rd_mem});
      if (pend_r && !replay) begin
        out_nxt = mem_q;
        ov_nxt  = 1'b1;
      end else if (off_rd) begin
        out_nxt = DCF_WIDTH'(off_val);
      end else if (take_ft) begin
        ov_nxt  = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      pend_r   <= 1'b0;
      ov_r     <= 1'b0;
      out_r    <= DCF_OUT_RESET;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      pend_r   <= pend_nxt;
      ov_r     <= ov_nxt;
      out_r    <= out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration and offset registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ft_mode_r     <= 1'b0;
      serial_mode_r <= 1'b0;
      empty_off_r   <= OFF_LO;
      full_off_r    <= OFF_LO;
    end else if (!full_clear_reset_n) begin
      ft_mode_r     <= fallthrough_serial_pin;
      serial_mode_r <= offset_access_select_n;
      empty_off_r   <= def_off;
      full_off_r    <= def_off;
    end else if (ser_wr) begin
      {full_off_r, empty_off_r} <= ser_chain;
    end else if (par_wr) begin
      if (woff_idx_r == DCF_IDX_EMPTY) begin
        empty_off_r <= write_data_bus[AW-1:0];
      end else begin
        full_off_r  <= write_data_bus[AW-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      woff_idx_r <= DCF_IDX_EMPTY;
      roff_idx_r <= DCF_IDX_EMPTY;
    end else if (clr) begin
      woff_idx_r <= DCF_IDX_EMPTY;
      roff_idx_r <= DCF_IDX_EMPTY;
    end else begin
      woff_idx_r <= woff_idx_r ^ par_wr;
      roff_idx_r <= roff_idx_r ^ (off_rd & !pend_r);
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_r     <= 1'b0;
      space_r  <= 1'b1;
      ev_out_r <= 1'b0;
      afull_r  <= 1'b1;
      aempty_r <= 1'b0;
      half_r   <= 1'b1;
    end else begin
      oe_r     <= !output_enable_n;
      space_r  <= ft_mode_r ? (count_nxt == DEPTH_C) : (count_nxt != DEPTH_C);
      ev_out_r <= ft_mode_r ? !ov_nxt : (count_nxt != '0);
      afull_r  <= free_nxt > {1'b0, full_off_r};
      aempty_r <= count_nxt > {1'b0, empty_off_r};
      half_r   <= !(count_nxt > HALF_C);
    end
  end

  assign read_data_bus      = out_r;
  assign read_data_oe       = oe_r;
  assign full_space_output  = space_r;
  assign empty_valid_output = ev_out_r;
  assign almost_full_flag   = afull_r;
  assign almost_empty_flag  = aempty_r;
  assign half_level_flag    = half_r;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  dcf_mem #(
    .WIDTH (DCF_WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clock   (clock),
    .wr_en   (wr_mem),
    .wr_addr (wr_ptr_r),
    .wr_data (write_data_bus),
    .rd_en   (rd_mem),
    .rd_addr (rd_ptr_r),
    .rd_data (mem_q)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dcf_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  wire quiet = full_clear_reset_n & pointer_only_reset_n & replay_request_n;

  sequence first_ft_write;
    ft_mode_r && full_clear_reset_n && count_r == '0 && !ov_r && !pend_r && wr_mem;
  endsequence

  sequence stay_quiet;
    quiet [*3];
  endsequence

  a_clear_zeroes_state: assert property (
    !full_clear_reset_n |=> wr_ptr_r == '0 && rd_ptr_r == '0 && read_data_bus == '0)
    else $error("full clear did not zero pointers and output");

  a_clear_latches_mode: assert property (
    !full_clear_reset_n |=> ft_mode_r == $past(fallthrough_serial_pin)
                            && serial_mode_r == $past(offset_access_select_n))
    else $error("full clear did not latch configuration");

  a_ptr_reset_keeps: assert property (
    full_clear_reset_n && !pointer_only_reset_n |=> $stable(ft_mode_r) && $stable(empty_off_r)
                            && $stable(full_off_r) && count_r == '0 && read_data_bus == '0)
    else $error("pointer reset disturbed settings or left data");

  a_default_offset: assert property (
    !full_clear_reset_n && offset_access_select_n |=> empty_off_r == OFF_HI
                                                    && full_off_r == OFF_HI)
    else $error("default offset wrong");

  a_replay_rewinds: assert property (
    replay |=> rd_ptr_r == '0 && count_r == {1'b0, $past(wr_ptr_r)} + $past(wr_mem))
    else $error("replay did not rewind read pointer");

  a_write_advances: assert property (
    wr_mem |=> wr_ptr_r == AW'($past(wr_ptr_r) + 1'b1))
    else $error("write did not advance pointer");

  a_full_ignored: assert property (
    full && wr_req && !sel && !clr && !rd_mem && !replay |=> $stable(count_r) && $stable(wr_ptr_r))
    else $error("write while full changed the buffer");

  a_oe_follows: assert property (
    output_enable_n |=> !read_data_oe)
    else $error("read bus driven with output enable off");

  a_serial_gated: assert property (
    full_clear_reset_n && serial_mode_r && serial_load_enable_n |=>
      $stable(empty_off_r) && $stable(full_off_r))
    else $error("serial offsets changed without serial enable");

  a_fall_through: assert property (
    (first_ft_write ##0 stay_quiet) |=> !empty_valid_output
      && read_data_bus == $past(write_data_bus, DCF_FT_LATENCY))
    else $error("first word did not fall through");

  a_half_level: assert property (
    half_level_flag == (count_r <= HALF_C))
    else $error("half level flag wrong");

  a_std_empty: assert property (
    full_clear_reset_n && $past(full_clear_reset_n) && !ft_mode_r |->
      empty_valid_output == (count_r != '0))
    else $error("empty flag wrong in standard timing");

  a_full_space: assert property (
    full_clear_reset_n && $past(full_clear_reset_n) |->
      full_space_output == ((count_r != DEPTH_C) ^ ft_mode_r))
    else $error("full or space output wrong");

  a_almost_full: assert property (
    $stable(full_off_r) |-> almost_full_flag == (DEPTH_C - count_r > {1'b0, full_off_r}))
    else $error("almost full flag wrong");

  a_almost_empty: assert property (
    $stable(empty_off_r) |-> almost_empty_flag == (count_r > {1'b0, empty_off_r}))
    else $error("almost empty flag wrong");

  a_empty_read_ignored: assert property (
    rd_req && !sel && !mem_has && !clr && !replay && !wr_mem |=>
      $stable(rd_ptr_r) && $stable(count_r))
    else $error("read while empty changed the buffer");

  a_offset_readback: assert property (
    off_rd && !pend_r |=> read_data_bus == DCF_WIDTH'($past(empty_off_r))
                          || read_data_bus == DCF_WIDTH'($past(full_off_r)))
    else $error("offset read returned a wrong value");

endmodule // dcf_fifo

// >>> bench/dcf_producer.sv
// producer model that streams counted words into the fifo write port
`timescale 1ns/1ps
module dcf_producer (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // command from the bench
  input  wire logic                          start,
  input  wire logic [15:0]                   count,
  input  wire logic [dcf_pkg::DCF_WIDTH-1:0] base,
  input  wire logic                          gap,
  // fifo write port
  output logic                               write_enable_n,
  output logic      [dcf_pkg::DCF_WIDTH-1:0] write_data_bus,
  output logic                               busy
);
  import dcf_pkg::*;

  logic [15:0]          left_r;
  logic [DCF_WIDTH-1:0] next_r;
  wire logic            stall = gap && !write_enable_n;

  assign busy = (left_r != 16'h0000) || !write_enable_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_r         <= 16'h0000;
      next_r         <= 18'h00000;
      write_enable_n <= 1'b1;
      write_data_bus <= 18'h00000;
    end else if (start) begin
      left_r <= count;
      next_r <= base;
    end else if (left_r != 16'h0000 && !stall) begin
      write_enable_n <= 1'b0;
      write_data_bus <= next_r;
      next_r         <= next_r + 18'h00001;
      left_r         <= left_r - 16'h0001;
    end else begin
      // idle line shows the inverse so a stale word never looks valid
      write_enable_n <= 1'b1;
      write_data_bus <= ~write_data_bus;
    end
  end
endmodule // dcf_producer

// >>> bench/dual_clock_fifo_18bit_flags_tb_top.sv
// self-checking bench for the dual clock fifo with programmable flags
`timescale 1ns/1ps
module dual_clock_fifo_18bit_flags_tb_top;
  import dcf_pkg::*;

  typedef struct {int words; logic [4:0] flags;} dcf_row_type;
  localparam int DEPTH = DCF_DEPTH_SMALL;
  localparam int AW    = $clog2(DEPTH);

  logic clock, rst_n, full_clear_reset_n, pointer_only_reset_n, read_enable_n;
  logic replay_request_n, output_enable_n, fallthrough_serial_pin;
  logic serial_load_enable_n, offset_access_select_n, start, gap, busy, write_enable_n;
  logic read_data_oe, space, ev, af, ae, half;
  logic [15:0]          count;
  logic [DCF_WIDTH-1:0] base, write_data_bus, read_data_bus;
  logic [2*AW-1:0]      sbits = {AW'(3), AW'(9)};
  int                   num_errors = 0, checks_done = 0, cycles = 0, done_words;
  wire logic [4:0]      flags = {space, ev, af, ae, half};

  // ----------------------------------------------------------------
  // rows: words held, then {full_space, empty_valid, afull, aempty, half}
  // ----------------------------------------------------------------
  dcf_row_type rows [8] = '{'{1, 5'b11101}, '{127, 5'b11101}, '{128, 5'b11111},
    '{DEPTH/2, 5'b11111}, '{DEPTH/2+1, 5'b11110}, '{DEPTH-128, 5'b11110},
    '{DEPTH-127, 5'b11010}, '{DEPTH, 5'b01010}};

  dcf_fifo #(.DEPTH(DEPTH)) uut (
    .clock(clock), .rst_n(rst_n), .full_clear_reset_n(full_clear_reset_n),
    .pointer_only_reset_n(pointer_only_reset_n), .write_enable_n(write_enable_n),
    .write_data_bus(write_data_bus), .read_enable_n(read_enable_n),
    .replay_request_n(replay_request_n), .output_enable_n(output_enable_n),
    .read_data_bus(read_data_bus), .read_data_oe(read_data_oe),
    .fallthrough_serial_pin(fallthrough_serial_pin),
    .serial_load_enable_n(serial_load_enable_n),
    .offset_access_select_n(offset_access_select_n),
    .clock_ratio_select(1'b0),
    .full_space_output(space), .empty_valid_output(ev), .almost_full_flag(af),
    .almost_empty_flag(ae), .half_level_flag(half));

  dcf_producer prod (
    .clock(clock), .rst_n(rst_n), .start(start), .count(count), .base(base), .gap(gap),
    .write_enable_n(write_enable_n), .write_data_bus(write_data_bus), .busy(busy));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [DCF_WIDTH-1:0] seen, input logic [DCF_WIDTH-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fcr(input logic ft, input logic sel);
    @(posedge clock);
    full_clear_reset_n     <= 1'b0;
    fallthrough_serial_pin <= ft;
    offset_access_select_n <= sel;
    repeat (2) @(posedge clock);
    full_clear_reset_n     <= 1'b1;
    offset_access_select_n <= 1'b1;
    fallthrough_serial_pin <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input int n, input logic [DCF_WIDTH-1:0] b, input logic g);
    int k;
    @(posedge clock);
    start <= 1'b1;
    count <= 16'(n);
    base  <= b;
    gap   <= g;
    @(posedge clock);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (busy === 1'b1 && k < 20000);
  endtask

  task automatic rd();
    @(posedge clock);
    read_enable_n <= 1'b0;
    @(posedge clock);
    read_enable_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic pulse_low(input int which);
    @(posedge clock);
    if (which == 0) pointer_only_reset_n <= 1'b0;
    else replay_request_n <= 1'b0;
    @(posedge clock);
    pointer_only_reset_n <= 1'b1;
    replay_request_n     <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; full_clear_reset_n = 1'b1; pointer_only_reset_n = 1'b1;
    read_enable_n = 1'b1; replay_request_n = 1'b1; output_enable_n = 1'b1;
    fallthrough_serial_pin = 1'b0; serial_load_enable_n = 1'b1;
    offset_access_select_n = 1'b1; start = 1'b0; count = 16'h0000; base = 18'h00000;
    gap = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    chk(flags, 5'b10101);
    chk(read_data_bus, DCF_OUT_RESET);
    chk(read_data_oe, 1'b0);
    @(posedge clock) rst_n <= 1'b1;
    fcr(1'b0, 1'b0);
    @(posedge clock) output_enable_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(read_data_oe, 1'b1);
    done_words = 0;
    foreach (rows[i]) begin
      wr(rows[i].words - done_words, 18'(32'h100 + done_words), 1'(i % 2));
      done_words = rows[i].words;
      chk(flags, rows[i].flags);
    end
    wr(1, 18'h3ffff, 1'b0);
    chk(flags, 5'b01010);
    rd();
    chk(read_data_bus, 18'h00100);
    rd();
    chk(read_data_bus, 18'h00101);
    pulse_low(0);
    chk(flags, 5'b10101);
    chk(read_data_bus, DCF_OUT_RESET);
    @(posedge clock) offset_access_select_n <= 1'b0;
    wr(2, 18'h00005, 1'b1);
    rd();
    chk(read_data_bus, 18'h00005);
    rd();
    chk(read_data_bus, 18'h00006);
    pulse_low(0);
    rd();
    chk(read_data_bus, 18'h00005);
    rd();
    chk(read_data_bus, 18'h00006);
    @(posedge clock) offset_access_select_n <= 1'b1;
    wr(5, 18'h00200, 1'b0);
    chk(flags, 5'b11101);
    wr(1, 18'h00205, 1'b0);
    chk(flags, 5'b11111);
    rd();
    chk(read_data_bus, 18'h00200);
    rd();
    chk(read_data_bus, 18'h00201);
    pulse_low(1);
    rd();
    chk(read_data_bus, 18'h00200);
    fcr(1'b0, 1'b1);
    @(posedge clock) offset_access_select_n <= 1'b0;
    rd();
    chk(read_data_bus, 18'h003ff);
    rd();
    chk(read_data_bus, 18'h003ff);
    for (int k = 0; k < 2 * AW; k++) begin
      @(posedge clock);
      serial_load_enable_n   <= 1'b0;
      fallthrough_serial_pin <= sbits[k];
    end
    @(posedge clock);
    serial_load_enable_n   <= 1'b1;
    fallthrough_serial_pin <= 1'b1;
    rd();
    chk(read_data_bus, 18'h00009);
    rd();
    chk(read_data_bus, 18'h00003);
    @(posedge clock) offset_access_select_n <= 1'b1;
    fcr(1'b1, 1'b0);
    #1;
    chk({space, ev}, 2'b01);
    wr(1, 18'h2abcd, 1'b0);
    repeat (4) @(posedge clock);
    #1;
    chk(ev, 1'b0);
    chk(read_data_bus, 18'h2abcd);
    rd();
    chk(ev, 1'b1);
    test_done();
  end
endmodule // dual_clock_fifo_18bit_flags_tb_top
